// ---- logic/rs485_dir_consts.vh ----
// Register offsets, field positions, reset values and prescale counts of the direction block
`ifndef RS485_DIR_CONSTS_VH
`define RS485_DIR_CONSTS_VH

// Byte offsets of the word registers
`define OFS_PORT_CTRL 8'h00
`define OFS_LINE_TIMING 8'h04
`define OFS_LINE_STATUS 8'h08

// Port control field positions, one bit per port in each 4-bit group
`define POS_AUTO_SEL 0
`define POS_RTS_SEL 4
`define POS_NO_ECHO 8
`define POS_RS485 12
`define POS_PRESCALE_ONE 16

// Line timing field positions
`define POS_BIT_CYCLES 0
`define POS_IDLE_BITS 16

// Line status field positions
`define POS_DRIVE_EN 0
`define POS_RX_BLANK 4
`define POS_AUTO_BUSY 8

// Reset values
`define RST_PORT_CTRL 32'h0000_0000
`define RST_BIT_CYCLES 16'h00ae
`define RST_IDLE_BITS 4'hb

// Prescale: terminal count of the divide-by-8 counter
`define PRESCALE_EIGHT_LAST 3'h7

`endif

// ---- logic/port_direction.v ----
// Per-port driver enable, echo suppression and line data path for one serial port
`timescale 1ns/100ps
module port_direction (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Serial controller side
   input wire ctl_txd,
   input wire ctl_rts_n,
   output reg ctl_rxd,
   // Line side, receive data already filtered
   input wire rx_line,
   output reg line_txd,
   output reg line_drive_en,
   output reg line_rx_en_n,
   // Settings
   input wire auto_drive_enable_sel,
   input wire modem_line_drive_enable_sel,
   input wire no_echo_sel,
   input wire rs485_sel,
   input wire [15:0] bit_cycles,
   input wire [3:0] idle_bits,
   // State for status readback
   output reg auto_busy
);

   reg [15:0] cycle_count; // Cycles into the current idle bit time
   reg [3:0] bit_count; // Whole idle bit times seen since last low
   reg next_busy;
   reg next_drive;
   reg blank;

   // Automatic enable tracker: start bit turns on, a full idle gap turns off
   always @(posedge clk) begin
      if (rst) begin
         auto_busy <= 1'b0;
         cycle_count <= 16'h0000;
         bit_count <= 4'h0;
      end else begin
         auto_busy <= next_busy;
         if (!auto_busy || !ctl_txd) begin
            // Any low bit restarts the gap measurement
            cycle_count <= 16'h0000;
            bit_count <= 4'h0;
         end else if (cycle_count + 16'h0001 >= bit_cycles) begin
            cycle_count <= 16'h0000;
            bit_count <= bit_count + 4'h1;
         end else begin
            cycle_count <= cycle_count + 16'h0001;
         end
      end
   end

   // Busy ends only after idle_bits whole high bit times, so the last stop bit is out
   always @* begin
      next_busy = auto_busy;
      if (!auto_drive_enable_sel) begin
         next_busy = 1'b0;
      end else if (!ctl_txd) begin
         next_busy = 1'b1;
      end else if (auto_busy && bit_count >= idle_bits && idle_bits != 4'h0) begin
         next_busy = 1'b0;
      end
   end

   // Driver enable by mode; automatic wins if both selections are on
   always @* begin
      if (!rs485_sel) begin
         next_drive = 1'b1;
      end else if (auto_drive_enable_sel) begin
         next_drive = next_busy;
      end else if (modem_line_drive_enable_sel) begin
         next_drive = ~ctl_rts_n;
      end else begin
         next_drive = 1'b1;
      end
      // Receiver blanked only on a switched line while we drive it
      blank = rs485_sel & no_echo_sel & (auto_drive_enable_sel | modem_line_drive_enable_sel) & next_drive;
   end

   // Registered pins; data and enable move in the same cycle so no bit is clipped
   always @(posedge clk) begin
      if (rst) begin
         line_txd <= 1'b1;
         line_drive_en <= 1'b0;
         line_rx_en_n <= 1'b0;
         ctl_rxd <= 1'b1;
      end else begin
         line_txd <= ctl_txd;
         line_drive_en <= next_drive;
         line_rx_en_n <= blank;
         ctl_rxd <= blank ? 1'b1 : rx_line;
      end
   end

endmodule // port_direction

// ---- logic/rs485_direction_and_baud_prescale.v ----
// Four-port transceiver direction control and baud reference prescaler with a Wishbone slave
`timescale 1ns/100ps
`include "rs485_dir_consts.vh"
module rs485_direction_and_baud_prescale #(
   parameter PORTS = 4
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Wishbone classic slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Serial controller side
   input wire [PORTS-1:0] ctl_txd,
   input wire [PORTS-1:0] ctl_rts_n,
   output wire [PORTS-1:0] ctl_rxd,
   output reg baud_ref,
   // Line transceiver side
   input wire [PORTS-1:0] line_rxd,
   output wire [PORTS-1:0] line_txd,
   output wire [PORTS-1:0] line_drive_en,
   output wire [PORTS-1:0] line_rx_en_n,
   output reg [PORTS-1:0] rs485_select
);

   ////////////////////////////////////////////////////////////////////////////////
   // Settings registers

   reg [PORTS-1:0] auto_drive_enable_sel; // Automatic driver enable per port
   reg [PORTS-1:0] modem_line_drive_enable_sel; // RTS driven enable per port
   reg [PORTS-1:0] no_echo_sel; // Suppress own transmissions per port
   reg prescale_by_one; // High: divide by 1, low: divide by 8
   reg [15:0] bit_cycles; // Clock cycles in one bit time of the controller
   reg [3:0] idle_bits; // Idle bit times that end an automatic burst

   wire [PORTS-1:0] auto_busy; // Automatic burst in progress per port
   wire access; // A new bus request this cycle
   wire [5:0] word_index; // Word address of the request

   // Byte lane merge used by every writable register
   function [31:0] lane_merge;
      input [31:0] old_value;
      input [31:0] new_value;
      input [3:0] lanes;
      integer i;
      begin
         lane_merge = old_value;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               lane_merge[i*8 +: 8] = new_value[i*8 +: 8];
            end
         end
      end
   endfunction

   // Assemble the port control word from the separate fields
   function [31:0] ctrl_word;
      input [3:0] a;
      input [3:0] r;
      input [3:0] n;
      input [3:0] s;
      input p;
      begin
         ctrl_word = 32'h0000_0000;
         ctrl_word[`POS_AUTO_SEL +: 4] = a;
         ctrl_word[`POS_RTS_SEL +: 4] = r;
         ctrl_word[`POS_NO_ECHO +: 4] = n;
         ctrl_word[`POS_RS485 +: 4] = s;
         ctrl_word[`POS_PRESCALE_ONE] = p;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   // A request is new only while no ack is out, so each access is taken once
   assign access = cyc_i & stb_i & ~ack_o;
   assign word_index = adr_i[7:2];

   // Ack follows one cycle after the request and drops the cycle after
   always @(posedge clk) begin
      if (rst) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= access;
      end
   end

   // Register writes, lane by lane; unmapped writes are acked and dropped
   always @(posedge clk) begin : reg_write
      reg [31:0] merged;
      merged = 32'h0000_0000;
      if (rst) begin
         auto_drive_enable_sel <= {PORTS{1'b0}};
         modem_line_drive_enable_sel <= {PORTS{1'b0}};
         no_echo_sel <= {PORTS{1'b0}};
         rs485_select <= {PORTS{1'b0}}; // RS-232 until software picks otherwise
         prescale_by_one <= 1'b0; // Conventional rates by default
         bit_cycles <= `RST_BIT_CYCLES;
         idle_bits <= `RST_IDLE_BITS;
      end else if (access && we_i) begin
         case ({2'b00, word_index})
            `OFS_PORT_CTRL >> 2: begin
               merged = lane_merge(ctrl_word(auto_drive_enable_sel, modem_line_drive_enable_sel,
                                             no_echo_sel, rs485_select, prescale_by_one), dat_i, sel_i);
               auto_drive_enable_sel <= merged[`POS_AUTO_SEL +: 4];
               modem_line_drive_enable_sel <= merged[`POS_RTS_SEL +: 4];
               no_echo_sel <= merged[`POS_NO_ECHO +: 4];
               rs485_select <= merged[`POS_RS485 +: 4];
               prescale_by_one <= merged[`POS_PRESCALE_ONE];
            end
            `OFS_LINE_TIMING >> 2: begin
               merged = lane_merge({12'h000, idle_bits, bit_cycles}, dat_i, sel_i);
               bit_cycles <= merged[`POS_BIT_CYCLES +: 16];
               idle_bits <= merged[`POS_IDLE_BITS +: 4];
            end
            default: begin
               // Read-only or unmapped word: nothing changes
            end
         endcase
      end
   end

   // Read data is registered with the ack; unmapped reads return zero
   always @(posedge clk) begin
      if (rst) begin
         dat_o <= 32'h0000_0000;
      end else if (access && !we_i) begin
         case ({2'b00, word_index})
            `OFS_PORT_CTRL >> 2: begin
               dat_o <= ctrl_word(auto_drive_enable_sel, modem_line_drive_enable_sel,
                                  no_echo_sel, rs485_select, prescale_by_one);
            end
            `OFS_LINE_TIMING >> 2: begin
               dat_o <= {12'h000, idle_bits, bit_cycles};
            end
            `OFS_LINE_STATUS >> 2: begin
               dat_o <= {20'h00000, auto_busy, line_rx_en_n, line_drive_en};
            end
            default: begin
               dat_o <= 32'h0000_0000;
            end
         endcase
      end else begin
         dat_o <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Baud reference prescaler

   reg [2:0] prescale_count; // Free-running divide-by-8 counter

   // One enable pulse per 8 clocks, or every clock when dividing by one.
   // The controller divides this further; with the right base clock the
   // eight-way path lands on the usual PC rates and the direct path on 921.6K.
   always @(posedge clk) begin
      if (rst) begin
         prescale_count <= 3'h0;
         baud_ref <= 1'b0;
      end else begin
         prescale_count <= prescale_count + 3'h1;
         if (prescale_by_one) begin
            baud_ref <= 1'b1;
         end else begin
            baud_ref <= (prescale_count == `PRESCALE_EIGHT_LAST);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive line synchroniser

   reg [PORTS-1:0] rx_meta; // First stage, read only by the second
   reg [PORTS-1:0] rx_sync; // Second stage
   reg [PORTS-1:0] rx_late; // Third stage
   reg [PORTS-1:0] rx_clean; // Accepted level

   // Three flip-flops; a new level counts only when stages two and three agree,
   // which rejects a one-cycle glitch at the cost of one cycle of latency
   always @(posedge clk) begin : rx_filter
      integer k;
      if (rst) begin
         rx_meta <= {PORTS{1'b1}};
         rx_sync <= {PORTS{1'b1}};
         rx_late <= {PORTS{1'b1}};
         rx_clean <= {PORTS{1'b1}};
      end else begin
         rx_meta <= line_rxd;
         rx_sync <= rx_meta;
         rx_late <= rx_sync;
         for (k = 0; k < PORTS; k = k + 1) begin
            if (rx_sync[k] == rx_late[k]) begin
               rx_clean[k] <= rx_late[k];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-port direction logic

   genvar p;
   generate
      for (p = 0; p < PORTS; p = p + 1) begin : port
         // Each port carries its own selections and state; bit_cycles and idle_bits are common to all ports
         port_direction u_dir (
            .clk(clk),
            .rst(rst),
            .ctl_txd(ctl_txd[p]),
            .ctl_rts_n(ctl_rts_n[p]),
            .ctl_rxd(ctl_rxd[p]),
            .rx_line(rx_clean[p]),
            .line_txd(line_txd[p]),
            .line_drive_en(line_drive_en[p]),
            .line_rx_en_n(line_rx_en_n[p]),
            .auto_drive_enable_sel(auto_drive_enable_sel[p]),
            .modem_line_drive_enable_sel(modem_line_drive_enable_sel[p]),
            .no_echo_sel(no_echo_sel[p]),
            .rs485_sel(rs485_select[p]),
            .bit_cycles(bit_cycles),
            .idle_bits(idle_bits),
            .auto_busy(auto_busy[p])
         );
      end
   endgenerate

endmodule // rs485_direction_and_baud_prescale

// ---- test/rs485_dir_chk.sv ----
// Checker of driver direction, echo blanking and baud prescale at the block's ports
`timescale 1ns/100ps
module rs485_dir_chk #(
   parameter PORTS = 4
) (
   // Clock, reset and bus
   input wire clk,
   input wire rst,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire ack_o,
   // Port side
   input wire [PORTS-1:0] ctl_txd,
   input wire [PORTS-1:0] ctl_rts_n,
   input wire [PORTS-1:0] ctl_rxd,
   input wire baud_ref,
   input wire [PORTS-1:0] line_drive_en,
   input wire [PORTS-1:0] line_rx_en_n,
   input wire [PORTS-1:0] rs485_select
);
   reg [16:0] sh; // Shadow of the port control word
   wire [3:0] au = sh[3:0]; // Auto drive selections
   wire [3:0] rt = sh[7:4]; // Modem line drive selections
   wire [3:0] ne = sh[11:8]; // No-echo selections
   wire [3:0] rs = sh[15:12]; // RS-485 selections
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Shadow updates at the taking edge, as the block's own register does
   always @(posedge clk) begin
      if (rst) begin
         sh <= 17'h0;
      end else if (cyc_i && stb_i && we_i && !ack_o && adr_i[7:2] == 6'h00) begin
         if (sel_i[0]) sh[7:0] <= dat_i[7:0];
         if (sel_i[1]) sh[15:8] <= dat_i[15:8];
         if (sel_i[2]) sh[16] <= dat_i[16];
      end
   end
   ////////////////////////////////////////////////////////////////
   a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held over two cycles");
   // The driver only turns on one edge after reset release, so the edge still in reset starts no attempt
   a_rs232_drive: assert property (!rst |=> (~$past(rs485_select) & ~line_drive_en) == '0)
      else $error("driver off in RS-232 mode");
   a_fixed_drive: assert property (1 |=> ($past(rs & ~au & ~rt) & ~line_drive_en) == 4'h0)
      else $error("fixed driver switched");
   a_rts_gate: assert property (1 |=> ($past(rs & ~au & rt) & (line_drive_en ^ ~$past(ctl_rts_n))) == 4'h0)
      else $error("driver not following RTS");
   a_auto_start: assert property (1 |=> ($past(rs & au & ~ctl_txd) & ~line_drive_en) == 4'h0)
      else $error("auto driver off while sending");
   a_auto_quiet: assert property (1 |=> ($past(rs & au & ctl_txd & ~line_drive_en) & line_drive_en) == 4'h0)
      else $error("auto driver on while idle");
   a_echo_rx: assert property (1 |=> ($past(~(rs & ne & (au | rt))) & line_rx_en_n) == 4'h0)
      else $error("receiver off in echo mode");
   a_blank_rxd: assert property ((line_rx_en_n & ~ctl_rxd) == '0)
      else $error("receive data not idle while blanked");
   a_prescale_by_eight_gap: assert property (baud_ref && !sh[16] |=> (!baud_ref || sh[16])[*7])
      else $error("baud pulse too early");
   a_prescale_by_eight_period: assert property (baud_ref && !sh[16] ##1 (!sh[16])[*7] |=> baud_ref)
      else $error("baud pulse missing");
   a_prescale_by_one_level: assert property (sh[16] |=> baud_ref)
      else $error("baud reference low in divide by one");
endmodule // rs485_dir_chk

bind rs485_direction_and_baud_prescale rs485_dir_chk #(.PORTS(PORTS)) chk (.clk(clk), .rst(rst),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .ack_o(ack_o), .ctl_txd(ctl_txd), .ctl_rts_n(ctl_rts_n), .ctl_rxd(ctl_rxd), .baud_ref(baud_ref),
   .line_drive_en(line_drive_en), .line_rx_en_n(line_rx_en_n), .rs485_select(rs485_select));

// ---- test/line_node.sv ----
// Other node on each shared line, and the level that the line settles to
`timescale 1ns/100ps
module line_node #(
   parameter PORTS = 4
) (
   // Device driver side
   input wire [PORTS-1:0] line_txd,
   input wire [PORTS-1:0] line_drive_en,
   // Bench commands for this node
   input wire [PORTS-1:0] node_en,
   input wire [PORTS-1:0] node_bit,
   // Line level seen by the receivers
   output wire [PORTS-1:0] line_rxd
);
   // Node yields while the device drives, so only one driver is ever on
   wire [PORTS-1:0] node_drives = node_en & ~line_drive_en;
   // A released line floats to the idle mark level of the bias network
   assign line_rxd = (line_drive_en & line_txd) | (node_drives & node_bit) | ~(line_drive_en | node_drives);
endmodule // line_node

// ---- test/tb.sv ----
// Bench for the direction and prescale block
`timescale 1ns/100ps
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg cyc_i = 1'b0;
   reg stb_i = 1'b0;
   reg we_i = 1'b0;
   reg [7:0] adr_i = 8'h00;
   reg [3:0] sel_i = 4'h0;
   reg [31:0] dat_i = 32'h0;
   reg [3:0] ctl_txd = 4'hf;
   reg [3:0] ctl_rts_n = 4'hf;
   reg [3:0] node_en = 4'h0;
   reg [3:0] node_bit = 4'hf;
   wire [31:0] dat_o;
   wire ack_o;
   wire baud_ref;
   wire [3:0] ctl_rxd, line_rxd, line_txd, line_drive_en, line_rx_en_n, rs485_select;
   integer failures = 0;
   integer n_compared = 0;
   integer i;
   integer cnt;
   reg [31:0] rd;
   always #25 clk = ~clk;
   rs485_direction_and_baud_prescale #(.PORTS(4)) dut (.clk(clk), .rst(rst), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .ctl_txd(ctl_txd), .ctl_rts_n(ctl_rts_n), .ctl_rxd(ctl_rxd), .baud_ref(baud_ref),
      .line_rxd(line_rxd), .line_txd(line_txd), .line_drive_en(line_drive_en),
      .line_rx_en_n(line_rx_en_n), .rs485_select(rs485_select));
   line_node #(.PORTS(4)) node (.line_txd(line_txd), .line_drive_en(line_drive_en), .node_en(node_en),
      .node_bit(node_bit), .line_rxd(line_rxd));
   ////////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input [31:0] exp, input [31:0] got, input [8*12-1:0] what);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // One classic cycle; request held until ack is sampled
   task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
      integer k;
      begin
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i <= w;
         adr_i <= a;
         sel_i <= s;
         dat_i <= d;
         k = 0;
         @(posedge clk);
         while (ack_o !== 1'b1 && k < 20) begin
            @(posedge clk);
            k = k + 1;
         end
         rd = dat_o;
         if (k == 20) chk(1, 0, "bus ack");
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] exp, input [8*12-1:0] what);
      begin
         wb(1'b0, a, 4'hf, 32'h0);
         chk(exp, rd, what);
      end
   endtask
   task end_sim;
      begin
         if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Watchdog well beyond the roughly 180 cycles the tests need
   initial begin
      repeat (4000) @(posedge clk);
      failures = failures + 1;
      end_sim;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdchk(8'h00, 32'h0, "port_ctrl");
      rdchk(8'h04, 32'h000b_00ae, "line_timing");
      rdchk(8'h08, 32'h0000_000f, "status");
      wb(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
      rdchk(8'h0c, 32'h0, "unmapped");
      wb(1'b1, 8'h08, 4'hf, 32'h0);
      rdchk(8'h08, 32'h0000_000f, "status ro");
      wb(1'b1, 8'h00, 4'h0, 32'hffff_ffff);
      // Ports: 0 auto echo, 1 auto no-echo, 2 RTS no-echo, 3 fixed
      wb(1'b1, 8'h00, 4'hf, 32'h0000_f643);
      wb(1'b1, 8'h04, 4'hf, 32'h0002_0004);
      rdchk(8'h00, 32'h0000_f643, "port_ctrl w");
      chk(4'hf, rs485_select, "select");
      chk(4'h8, line_drive_en, "idle drive");
      // Two characters with a short gap, then idle
      ctl_txd <= 4'hc;
      repeat (20) @(posedge clk);
      chk(2'h3, line_drive_en[1:0], "auto on");
      chk(2'h2, ctl_rxd[1:0], "echo");
      chk(2'h2, line_rx_en_n[1:0], "rx enable");
      ctl_txd <= 4'hf;
      repeat (6) @(posedge clk);
      chk(2'h3, line_drive_en[1:0], "stop hold");
      ctl_txd <= 4'hc;
      repeat (8) @(posedge clk);
      chk(2'h3, line_drive_en[1:0], "queued");
      ctl_txd <= 4'hf;
      repeat (12) @(posedge clk);
      chk(2'h0, line_drive_en[1:0], "auto off");
      rdchk(8'h08, 32'h0000_0008, "status idle");
      // Driver gated from RTS
      ctl_rts_n <= 4'hb;
      repeat (2) @(posedge clk);
      chk(4'hc, line_drive_en, "rts on");
      chk(4'h4, line_rx_en_n, "rts blank");
      ctl_rts_n <= 4'hf;
      repeat (2) @(posedge clk);
      chk(4'h8, line_drive_en, "rts off");
      // Other node talks; device stays off and listens
      node_en <= 4'h3;
      node_bit <= 4'h0;
      repeat (8) @(posedge clk);
      chk(2'h0, ctl_rxd[1:0], "node data");
      chk(4'h8, line_drive_en, "yield");
      node_en <= 4'h0;
      node_bit <= 4'hf;
      // Baud reference
      cnt = 0;
      for (i = 0; i < 64; i = i + 1) begin
         @(posedge clk);
         cnt = cnt + baud_ref;
      end
      chk(8, cnt, "prescale_by_eight pulses");
      wb(1'b1, 8'h00, 4'h4, 32'h0001_0000);
      repeat (3) @(posedge clk);
      chk(1, baud_ref, "prescale_by_one");
      rdchk(8'h00, 32'h0001_f643, "lanes");
      end_sim;
   end
endmodule // tb
